// [pkg/mp_pkg.sv]
// Purpose: shared constants and types of the memory protect block
// Assumes: byte-level host access, 2-wire bit timing handled outside
// Notes: offsets are byte offsets within a device address space
package mp_pkg;
   // device addresses, bit 0 (read/write) is ignored on compare
   localparam logic [7:0] DEV_AUX = 8'hA0;
   localparam logic [7:0] DEV_MAIN_DFLT = 8'hA2;
   // main lower space
   localparam logic [7:0] OFS_SRAM_LO = 8'h60;
   localparam logic [7:0] OFS_TEMP_MSB = 8'h60;
   localparam logic [7:0] OFS_TEMP_LSB = 8'h61;
   localparam logic [7:0] OFS_RO_HI = 8'h6D;
   localparam logic [7:0] OFS_LOGIC = 8'h6E;
   localparam logic [7:0] OFS_TABLE_SEL = 8'h7F;
   // config table bytes
   localparam logic [7:0] OFS_RES0_MAN = 8'h82;
   localparam logic [7:0] OFS_RES1_MAN = 8'h83;
   localparam logic [7:0] OFS_PROT_CFG = 8'h89;
   localparam logic [7:0] OFS_MAIN_ADDR = 8'h8C;
   // table codes written at 7Fh
   localparam logic [7:0] TBL_EXTRA = 8'h00;
   localparam logic [7:0] TBL_CONFIG = 8'h01;
   localparam logic [7:0] TBL_LUT0 = 8'h02;
   localparam logic [7:0] TBL_LUT1 = 8'h03;
   localparam logic [7:0] TBL_AUX = 8'h04;
   // protect_configuration fields
   localparam int CFG_MAIN_PROTECT_BIT_BIT = 0;
   localparam int CFG_AUX_PROTECT_BIT_BIT = 1;
   localparam int CFG_SINGLE_ADDRESS_SELECT_BIT = 2;
   localparam int CFG_MAIN_ADDRESS_FROM_EEPROM_BIT = 3;
   localparam int CFG_TEN_BIT = 4;
   // logic-state byte fields
   localparam int LOGIC_STA_BIT = 7;
   localparam int LOGIC_CTL_BIT = 6;
   // reset values
   localparam logic [7:0] PROT_CFG_RST = 8'h10;
   localparam logic [7:0] MAIN_ADDR_RST = 8'hA2;
   localparam logic [7:0] TABLE_SEL_RST = 8'h01;
   localparam logic [7:0] RES_MAN_RST = 8'h00;
   // temperature lookup
   localparam logic [7:0] LUT_FIRST = 8'h80;
   localparam logic [7:0] LUT_LAST = 8'hC7;
   localparam logic signed [8:0] TEMP_MIN_C = 9'sh1D8; // -40
   localparam logic signed [8:0] TEMP_MAX_C = 9'sh066; // +102
   typedef enum logic [2:0] {
      RG_NONE, RG_AUX, RG_MAIN_LO, RG_EXTRA, RG_CONFIG, RG_LUT0, RG_LUT1
   } mp_region_e;
endpackage : mp_pkg

// [rtl/mp_temp_index.sv]
// Purpose: temperature integer degrees to lookup address
// Assumes: input is the signed upper byte of the temperature word
// Notes: purely combinational
`timescale 1ns/1ps
`default_nettype none
module mp_temp_index
   import mp_pkg::*;
(
   input wire logic [7:0] temp_int, // signed whole degrees
   output logic [7:0] lut_index // 80h..C7h
);
   logic signed [8:0] t;
   logic [8:0] ofs;
   assign t = {temp_int[7], temp_int};
   assign ofs = 9'(t - TEMP_MIN_C);
   always_comb begin
      if (t <= TEMP_MIN_C) begin
         lut_index = LUT_FIRST;
      end else if (t >= TEMP_MAX_C) begin
         lut_index = LUT_LAST;
      end else begin
         // floor of the byte keeps odd degrees in the lower step
         lut_index = LUT_FIRST + {1'b0, ofs[7:1]};
      end
   end
endmodule : mp_temp_index
`default_nettype wire

// [rtl/mp_decode.sv]
// Purpose: device address decode, table selection and write protect
// Assumes: config bits are stable registers of the top
// Notes: combinational
`timescale 1ns/1ps
`default_nettype none
module mp_decode
   import mp_pkg::*;
(
   input wire logic [7:0] dev_addr, // device address byte
   input wire logic [7:0] offset, // byte offset
   input wire logic [7:0] table_sel, // table select byte
   input wire logic single_address_select, // one address mode
   input wire logic main_address_from_eeprom, // use stored address
   input wire logic [7:0] main_addr, // stored main address
   input wire logic main_protect_bit, // main protect
   input wire logic aux_protect_bit, // aux protect
   input wire logic write_protect_pin, // protect pin
   output logic dev_hit, // address acknowledged
   output mp_region_e region, // memory reached
   output logic wr_ok // write permitted
);
   logic [7:0] main_id;
   logic is_main;
   logic is_aux;
   logic prot_main;
   assign main_id = main_address_from_eeprom ? main_addr
                                             : DEV_MAIN_DFLT;
   assign is_main = dev_addr[7:1] == main_id[7:1];
   // aux answers only in two-address mode
   assign is_aux = !single_address_select && !is_main &&
                   dev_addr[7:1] == DEV_AUX[7:1];
   assign dev_hit = is_main | is_aux;
   assign prot_main = write_protect_pin & main_protect_bit;
   always_comb begin
      region = RG_NONE;
      if (is_main && !offset[7]) begin
         region = RG_MAIN_LO;
      end else if (is_main) begin
         case (table_sel)
            TBL_EXTRA: region = single_address_select ? RG_EXTRA
                                                      : RG_NONE;
            TBL_CONFIG: region = RG_CONFIG;
            TBL_LUT0: region = RG_LUT0;
            TBL_LUT1: region = RG_LUT1;
            TBL_AUX: region = single_address_select ? RG_NONE
                                                    : RG_AUX;
            default: region = RG_NONE;
         endcase
      end else if (is_aux && !offset[7]) begin
         region = RG_AUX;
      end
   end
   always_comb begin
      case (region)
         RG_AUX: wr_ok = !aux_protect_bit;
         RG_EXTRA: wr_ok = !aux_protect_bit;
         RG_MAIN_LO: wr_ok = offset >= OFS_SRAM_LO || !prot_main;
         RG_CONFIG, RG_LUT0, RG_LUT1: wr_ok = !prot_main;
         default: wr_ok = 1'b0;
      endcase
   end
endmodule : mp_decode
`default_nettype wire

// [rtl/mp_top.sv]
// Purpose: memory map, protection and resistor lookup of the monitor
// Assumes: 2-wire framing outside; one byte access per acc_valid
// Notes: memory arrays have no reset, they model EEPROM and SRAM storage
`timescale 1ns/1ps
`default_nettype none
// Operation
// - lookup address from temperature, 2 degree steps
// - each entry holds two independent 8-bit positions
// - temperature reported as signed 16-bit word
// - disable pin high turns both resistors off
// - index disabled: positions from manual bytes
// - two-address mode answers A0h and main
// - single-address mode ignores aux, adds table 00
// - main address from stored byte or A2h
// - upper region main only, table by 7Fh
// - aux has no tables, mapped as table
// - protect bits writable through main only
// - main protected when pin and bit high
// - aux protection by aux bit alone
// - main bytes 60h to 7Fh never protected
// - table 00 protected by aux bit alone
// - reserved volatile bytes read 00h, writes ignored
// - locations change only when write permitted
// - control bit forces off; status shows off
module mp_top
   import mp_pkg::*;
(
   input wire logic core_clk, // 50 MHz clock
   input wire logic rst_n, // async reset, active low
   input wire logic acc_valid, // byte access request
   input wire logic acc_write, // 1 write, 0 read
   input wire logic [7:0] acc_dev_addr, // device address byte
   input wire logic [7:0] acc_offset, // byte offset
   input wire logic [7:0] acc_wdata, // write data
   output logic acc_ack, // device address answered
   output logic [7:0] acc_rdata, // read data
   output logic acc_rvalid, // read data valid
   input wire logic [15:0] temp_word, // measured temperature
   input wire logic resistor_disable_pin, // high turns resistors off
   input wire logic write_protect_pin, // protect enable pin
   output logic [7:0] res0_position, // resistor 0 setting
   output logic [7:0] res1_position, // resistor 1 setting
   output logic resistor_hiz // both resistors off
);
   logic rst_meta_n;
   logic rst_sync_n;
   logic [7:0] aux_mem [128];
   logic [7:0] low_mem [128];
   logic [7:0] ext_mem [128];
   logic [7:0] cfg_mem [128];
   logic [7:0] lut0_mem [128];
   logic [7:0] lut1_mem [128];
   logic [7:0] table_select;
   logic [7:0] resistor0_manual_position;
   logic [7:0] resistor1_manual_position;
   logic [7:0] protect_configuration;
   logic [7:0] main_device_address;
   logic resistor_hiz_control;
   logic dev_hit;
   mp_region_e region;
   logic wr_ok;
   logic wr;
   logic [6:0] ix;
   logic [7:0] lut_index;
   logic [7:0] next_rdata;
   logic [7:0] next_res0;
   logic [7:0] next_res1;
   logic temp_index_enable;
   logic low_ro;
   logic low_special;
   logic cfg_special;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_meta_n <= 1'b0;
         rst_sync_n <= 1'b0;
      end else begin
         rst_meta_n <= 1'b1;
         rst_sync_n <= rst_meta_n;
      end
   end

   assign temp_index_enable = protect_configuration[CFG_TEN_BIT];

   mp_decode u_decode (
      .dev_addr(acc_dev_addr),
      .offset(acc_offset),
      .table_sel(table_select),
      .single_address_select(protect_configuration[CFG_SINGLE_ADDRESS_SELECT_BIT]),
      .main_address_from_eeprom(protect_configuration[CFG_MAIN_ADDRESS_FROM_EEPROM_BIT]),
      .main_addr(main_device_address),
      .main_protect_bit(protect_configuration[CFG_MAIN_PROTECT_BIT_BIT]),
      .aux_protect_bit(protect_configuration[CFG_AUX_PROTECT_BIT_BIT]),
      .write_protect_pin(write_protect_pin),
      .dev_hit(dev_hit),
      .region(region),
      .wr_ok(wr_ok)
   );

   mp_temp_index u_temp_index (
      .temp_int(temp_word[15:8]),
      .lut_index(lut_index)
   );

   // a refused write still gets its acknowledge
   assign acc_ack = acc_valid & dev_hit;
   assign wr = acc_valid & acc_write & dev_hit & wr_ok;
   assign ix = acc_offset[6:0];
   // measured and reserved read-only bytes
   assign low_ro = acc_offset >= OFS_SRAM_LO && acc_offset <= OFS_RO_HI;
   assign low_special = low_ro || acc_offset == OFS_LOGIC ||
                        acc_offset == OFS_TABLE_SEL;
   assign cfg_special = acc_offset == OFS_RES0_MAN ||
                        acc_offset == OFS_RES1_MAN ||
                        acc_offset == OFS_PROT_CFG ||
                        acc_offset == OFS_MAIN_ADDR;

   // plain storage, no reset so contents model EEPROM/SRAM
   always_ff @(posedge core_clk) begin
      if (wr) begin
         case (region)
            RG_AUX: aux_mem[ix] <= acc_wdata;
            RG_MAIN_LO: begin
               if (!low_special) begin
                  low_mem[ix] <= acc_wdata;
               end
            end
            RG_EXTRA: ext_mem[ix] <= acc_wdata;
            RG_CONFIG: begin
               if (!cfg_special) begin
                  cfg_mem[ix] <= acc_wdata;
               end
            end
            RG_LUT0: lut0_mem[ix] <= acc_wdata;
            RG_LUT1: lut1_mem[ix] <= acc_wdata;
            default: ;
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         table_select <= TABLE_SEL_RST;
         resistor_hiz_control <= 1'b0;
      end else if (wr && region == RG_MAIN_LO) begin
         if (acc_offset == OFS_TABLE_SEL) begin
            table_select <= acc_wdata;
         end
         if (acc_offset == OFS_LOGIC) begin
            resistor_hiz_control <= acc_wdata[LOGIC_CTL_BIT];
         end
      end
   end

   // config registers sit in table 01, so only main can reach them
   always_ff @(posedge core_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         resistor0_manual_position <= RES_MAN_RST;
         resistor1_manual_position <= RES_MAN_RST;
         protect_configuration <= PROT_CFG_RST;
         main_device_address <= MAIN_ADDR_RST;
      end else if (wr && region == RG_CONFIG) begin
         case (acc_offset)
            OFS_RES0_MAN: resistor0_manual_position <= acc_wdata;
            OFS_RES1_MAN: resistor1_manual_position <= acc_wdata;
            OFS_PROT_CFG: protect_configuration <= acc_wdata;
            OFS_MAIN_ADDR: main_device_address <= acc_wdata;
            default: ;
         endcase
      end
   end

   always_comb begin
      next_rdata = 8'h00;
      case (region)
         RG_AUX: next_rdata = aux_mem[ix];
         RG_MAIN_LO: begin
            if (acc_offset == OFS_TEMP_MSB) begin
               next_rdata = temp_word[15:8];
            end else if (acc_offset == OFS_TEMP_LSB) begin
               next_rdata = temp_word[7:0];
            end else if (low_ro) begin
               next_rdata = 8'h00;
            end else if (acc_offset == OFS_LOGIC) begin
               next_rdata = 8'h00;
               next_rdata[LOGIC_STA_BIT] = resistor_hiz;
               next_rdata[LOGIC_CTL_BIT] = resistor_hiz_control;
            end else if (acc_offset == OFS_TABLE_SEL) begin
               next_rdata = table_select;
            end else begin
               next_rdata = low_mem[ix];
            end
         end
         RG_EXTRA: next_rdata = ext_mem[ix];
         RG_CONFIG: begin
            case (acc_offset)
               OFS_RES0_MAN: next_rdata = resistor0_manual_position;
               OFS_RES1_MAN: next_rdata = resistor1_manual_position;
               OFS_PROT_CFG: next_rdata = protect_configuration;
               OFS_MAIN_ADDR: next_rdata = main_device_address;
               default: next_rdata = cfg_mem[ix];
            endcase
         end
         RG_LUT0: next_rdata = lut0_mem[ix];
         RG_LUT1: next_rdata = lut1_mem[ix];
         default: next_rdata = 8'h00;
      endcase
   end

   always_ff @(posedge core_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         acc_rdata <= 8'h00;
         acc_rvalid <= 1'b0;
      end else begin
         acc_rvalid <= acc_valid & dev_hit & !acc_write;
         if (acc_valid && dev_hit && !acc_write) begin
            acc_rdata <= next_rdata;
         end
      end
   end

   // each lookup entry carries its own pair of positions
   always_comb begin
      if (temp_index_enable) begin
         next_res0 = lut0_mem[lut_index[6:0]];
         next_res1 = lut1_mem[lut_index[6:0]];
      end else begin
         next_res0 = resistor0_manual_position;
         next_res1 = resistor1_manual_position;
      end
   end

   always_ff @(posedge core_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         res0_position <= 8'h00;
         res1_position <= 8'h00;
         resistor_hiz <= 1'b1;
      end else begin
         res0_position <= next_res0;
         res1_position <= next_res1;
         // pin or control bit open both resistors together
         resistor_hiz <= resistor_disable_pin |
                         resistor_hiz_control;
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_sync_n);

   chk_lut_floor: assert property (
      $signed(temp_word[15:8]) <= -40 |-> lut_index == LUT_FIRST)
      else $error("lookup address not 80h at low temperature");
   chk_lut_ceiling: assert property (
      $signed(temp_word[15:8]) >= 102 |-> lut_index == LUT_LAST)
      else $error("lookup address not C7h at high temperature");
   chk_temp_read: assert property (
      acc_valid && !acc_write && region == RG_MAIN_LO &&
      acc_offset == OFS_TEMP_MSB |=> acc_rvalid &&
      acc_rdata == $past(temp_word[15:8]))
      else $error("temperature upper byte misreported");
   chk_hiz_pin: assert property (
      resistor_disable_pin |=> resistor_hiz)
      else $error("resistors on while disable pin high");
   chk_manual_pos: assert property (
      !temp_index_enable |=>
      res0_position == $past(resistor0_manual_position))
      else $error("manual position not applied");
   chk_aux_ignored: assert property (
      protect_configuration[CFG_SINGLE_ADDRESS_SELECT_BIT] &&
      acc_dev_addr[7:1] == DEV_AUX[7:1] && !dev_hit |-> !acc_ack ##1
      !acc_rvalid)
      else $error("aux address answered in single mode");
   chk_main_locked: assert property (
      acc_valid && acc_write && region == RG_CONFIG &&
      write_protect_pin && protect_configuration[CFG_MAIN_PROTECT_BIT_BIT] |=>
      $stable(main_device_address) && $stable(resistor0_manual_position))
      else $error("locked main memory changed");
   chk_sram_open: assert property (
      region == RG_MAIN_LO && acc_offset >= OFS_SRAM_LO |-> wr_ok)
      else $error("volatile main bytes write protected");
   chk_aux_protect: assert property (
      region == RG_AUX |-> wr_ok == !protect_configuration[CFG_AUX_PROTECT_BIT_BIT])
      else $error("aux protection ignores aux bit");
   chk_hiz_status: assert property (
      resistor_hiz_control |=> resistor_hiz ##0
      (region != RG_MAIN_LO || acc_offset != OFS_LOGIC ||
       next_rdata[LOGIC_STA_BIT]))
      else $error("control bit did not open resistors");
endmodule : mp_top
`default_nettype wire

// [test/mp_host_model.sv]
// Purpose: host controller side of the byte access port
// Assumes: one byte per request, driven at the falling edge
// Notes: released data lines show inverted values while idle
`timescale 1ns/1ps
`default_nettype none
module mp_host_model (
   input wire logic core_clk, // clock
   input wire logic acc_ack, // device answered
   input wire logic [7:0] acc_rdata, // read data
   input wire logic acc_rvalid, // read data valid
   output logic acc_valid, // request
   output logic acc_write, // 1 write
   output logic [7:0] acc_dev_addr, // device address
   output logic [7:0] acc_offset, // offset
   output logic [7:0] acc_wdata // write data
);
   initial begin
      acc_valid = 1'b0;
      acc_write = 1'b0;
      acc_dev_addr = 8'hFF;
      acc_offset = 8'h00;
      acc_wdata = 8'h00;
   end
   // ack is combinational, so look before the taking edge
   task automatic xfer(input logic [7:0] dev, input logic [7:0] ofs,
         input logic wr, input logic [7:0] wd, output logic ak,
         output logic rv, output logic [7:0] rd);
      @(negedge core_clk);
      acc_valid = 1'b1;
      acc_write = wr;
      acc_dev_addr = dev;
      acc_offset = ofs;
      acc_wdata = wd;
      #5;
      ak = acc_ack;
      @(negedge core_clk);
      acc_valid = 1'b0;
      // stale values must never pass for a fresh request
      acc_wdata = ~wd;
      acc_offset = ~ofs;
      rv = acc_rvalid;
      rd = acc_rdata;
   endtask : xfer
endmodule : mp_host_model
`default_nettype wire

// [test/tb.sv]
// Purpose: self-checking bench of the memory protect block
// Assumes: host model issues byte accesses, one at a time
// Notes: lookup tables are written before positions are judged
`timescale 1ns/1ps
`default_nettype none
module tb;
   import mp_pkg::*;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic acc_valid, acc_write, acc_ack, acc_rvalid, resistor_hiz;
   logic [7:0] acc_dev_addr, acc_offset, acc_wdata, acc_rdata;
   logic [7:0] res0_position, res1_position;
   logic [15:0] temp_word = 16'hD800;
   logic resistor_disable_pin = 1'b1;
   logic write_protect_pin = 1'b0;
   int fail_count = 0;
   int samples_checked = 0;
   int cycles = 0;
   always #10 core_clk = ~core_clk;
   mp_top dut (.core_clk(core_clk), .rst_n(rst_n), .acc_valid(acc_valid),
      .acc_write(acc_write), .acc_dev_addr(acc_dev_addr),
      .acc_offset(acc_offset), .acc_wdata(acc_wdata), .acc_ack(acc_ack),
      .acc_rdata(acc_rdata), .acc_rvalid(acc_rvalid),
      .temp_word(temp_word), .resistor_disable_pin(resistor_disable_pin),
      .write_protect_pin(write_protect_pin),
      .res0_position(res0_position), .res1_position(res1_position),
      .resistor_hiz(resistor_hiz));
   mp_host_model host (.core_clk(core_clk), .acc_ack(acc_ack),
      .acc_rdata(acc_rdata), .acc_rvalid(acc_rvalid),
      .acc_valid(acc_valid), .acc_write(acc_write),
      .acc_dev_addr(acc_dev_addr), .acc_offset(acc_offset),
      .acc_wdata(acc_wdata));
   task automatic final_report();
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : final_report
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk8
   task automatic tick(input int n);
      repeat (n) @(negedge core_clk);
   endtask : tick
   task automatic wr(input logic [7:0] dev, input logic [7:0] ofs,
         input logic [7:0] d);
      logic ak, rv;
      logic [7:0] rdv;
      host.xfer(dev, ofs, 1'b1, d, ak, rv, rdv);
      chk8({6'h0, ak, rv}, 8'h02);
   endtask : wr
   task automatic rd(input logic [7:0] dev, input logic [7:0] ofs,
         input logic [7:0] exp, input logic [7:0] m = 8'hFF);
      logic ak, rv;
      logic [7:0] rdv;
      host.xfer(dev, ofs, 1'b0, 8'h00, ak, rv, rdv);
      chk8({6'h0, ak, rv}, 8'h03);
      chk8(rdv & m, exp);
   endtask : rd
   task automatic noack(input logic [7:0] dev);
      logic ak, rv;
      logic [7:0] rdv;
      host.xfer(dev, 8'h00, 1'b0, 8'h00, ak, rv, rdv);
      chk8({6'h0, ak, rv}, 8'h00);
   endtask : noack
   task automatic t_reset();
      rd(8'hA2, OFS_TABLE_SEL, TABLE_SEL_RST);
      rd(8'hA2, OFS_PROT_CFG, PROT_CFG_RST);
      rd(8'hA2, OFS_MAIN_ADDR, MAIN_ADDR_RST);
      rd(8'hA2, OFS_RES0_MAN, RES_MAN_RST);
      rd(8'hA2, OFS_RES1_MAN, RES_MAN_RST);
      chk8({7'h0, resistor_hiz}, 8'h01);
   endtask : t_reset
   task automatic t_hiz();
      resistor_disable_pin = 1'b0;
      tick(3);
      chk8({7'h0, resistor_hiz}, 8'h00);
      wr(8'hA2, OFS_LOGIC, 8'h40);
      tick(2);
      chk8({7'h0, resistor_hiz}, 8'h01);
      rd(8'hA2, OFS_LOGIC, 8'hC0, 8'hC0);
      wr(8'hA2, OFS_LOGIC, 8'h00);
      tick(2);
      rd(8'hA2, OFS_LOGIC, 8'h00, 8'hC0);
      resistor_disable_pin = 1'b1;
      tick(3);
      chk8({7'h0, resistor_hiz}, 8'h01);
      resistor_disable_pin = 1'b0;
   endtask : t_hiz
   task automatic t_addr();
      noack(8'hA4);
      wr(8'hA0, 8'h10, 8'h33);
      rd(8'hA0, 8'h10, 8'h33);
      rd(8'hA0, 8'h80, 8'h00);
      wr(8'hA0, OFS_PROT_CFG, 8'hFF);
      rd(8'hA2, OFS_PROT_CFG, 8'h10);
      wr(8'hA2, OFS_TABLE_SEL, TBL_AUX);
      rd(8'hA2, 8'h90, 8'h33);
      wr(8'hA2, OFS_TABLE_SEL, TBL_CONFIG);
      wr(8'hA2, OFS_MAIN_ADDR, 8'hB0);
      wr(8'hA2, OFS_PROT_CFG, 8'h18);
      noack(8'hA2);
      rd(8'hB0, OFS_PROT_CFG, 8'h18);
      wr(8'hB0, OFS_PROT_CFG, 8'h14);
      noack(8'hA0);
      wr(8'hA2, OFS_TABLE_SEL, TBL_EXTRA);
      wr(8'hA2, 8'h85, 8'h77);
      rd(8'hA2, 8'h85, 8'h77);
      wr(8'hA2, OFS_TABLE_SEL, TBL_CONFIG);
      wr(8'hA2, OFS_PROT_CFG, 8'h10);
   endtask : t_addr
   task automatic t_prot();
      wr(8'hA2, OFS_PROT_CFG, 8'h11);
      wr(8'hA2, 8'h00, 8'h66);
      rd(8'hA2, 8'h00, 8'h66);
      write_protect_pin = 1'b1;
      wr(8'hA2, 8'h00, 8'h77);
      rd(8'hA2, 8'h00, 8'h66);
      wr(8'hA2, 8'h70, 8'h5A);
      rd(8'hA2, 8'h70, 8'h5A);
      wr(8'hA0, 8'h20, 8'h44);
      rd(8'hA0, 8'h20, 8'h44);
      wr(8'hA2, OFS_PROT_CFG, 8'h10);
      rd(8'hA2, OFS_PROT_CFG, 8'h11);
      write_protect_pin = 1'b0;
      // aux bit set in two-address mode so the aux port still answers
      wr(8'hA2, OFS_PROT_CFG, 8'h12);
      wr(8'hA0, 8'h20, 8'h45);
      wr(8'hA2, OFS_PROT_CFG, 8'h16);
      wr(8'hA2, OFS_TABLE_SEL, TBL_EXTRA);
      wr(8'hA2, 8'h85, 8'h78);
      rd(8'hA2, 8'h85, 8'h77);
      wr(8'hA2, OFS_TABLE_SEL, TBL_CONFIG);
      wr(8'hA2, OFS_PROT_CFG, 8'h10);
      rd(8'hA0, 8'h20, 8'h44);
   endtask : t_prot
   task automatic t_temp();
      logic [7:0] lut [4] = '{8'h80, 8'h81, 8'hC6, 8'hC7};
      logic [7:0] ti [8] = '{8'hD0, 8'hD8, 8'hD9, 8'hDA, 8'h64, 8'h65,
         8'h66, 8'h7F};
      logic [7:0] e;
      int t;
      wr(8'hA2, OFS_TABLE_SEL, TBL_LUT0);
      foreach (lut[i]) wr(8'hA2, lut[i], lut[i]);
      wr(8'hA2, OFS_TABLE_SEL, TBL_LUT1);
      foreach (lut[i]) wr(8'hA2, lut[i], ~lut[i]);
      wr(8'hA2, OFS_TABLE_SEL, TBL_CONFIG);
      foreach (ti[i]) begin
         temp_word = {ti[i], 8'h5A};
         t = $signed(ti[i]);
         if (t <= -40) e = LUT_FIRST;
         else if (t >= 102) e = LUT_LAST;
         else e = LUT_FIRST + 8'((t + 40) / 2);
         tick(3);
         chk8(res0_position, e);
         chk8(res1_position, ~e);
         rd(8'hA2, OFS_TEMP_MSB, ti[i]);
         rd(8'hA2, OFS_TEMP_LSB, 8'h5A);
      end
      wr(8'hA2, OFS_RES0_MAN, 8'h3C);
      wr(8'hA2, OFS_RES1_MAN, 8'hC3);
      wr(8'hA2, OFS_PROT_CFG, 8'h00);
      tick(3);
      chk8(res0_position, 8'h3C);
      chk8(res1_position, 8'hC3);
   endtask : t_temp
   // a hang must still end in the closing report
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 3000) begin
         fail_count++;
         $display("MISMATCH t=%0t timeout", $time);
         final_report();
      end
   end
   initial begin
      tick(6);
      rst_n = 1'b1;
      tick(3);
      t_reset();
      t_hiz();
      t_addr();
      t_prot();
      t_temp();
      final_report();
   end
endmodule : tb
`default_nettype wire
